// [hdl/dsrpd_lowpower.sv]
// Purpose: self-refresh and power-down state tracking of the memory die
// Assumes: inputs synchronous to clk; controller keeps its own timing duties
// Notes:   reset_n models the die reset pin, taken synchronously
//
// Overview of operation
// - self-refresh entry: cs, ras, cas, cke low, we high at clock edge
// - dll enabled: switched off on self-refresh entry, reset and on at exit
// - in self-refresh all inputs except cke and reset are ignored
// - an internal refresh within tcke, then periodic refresh from timer
// - exit is cke high alone, command not decoded; txs then txsdll before dll commands
// - power-down entered when cke sampled low with nop or deselect
// - all banks closed gives precharge power-down, else active
// - buffers off in power-down; receivers off after tcpded
// - active or a12 high: fast exit; a12 low precharge: dll off, slow
// - reset low during power-down goes straight to reset state
// - exit on cke high with nop; tcke hold; txp/txpdll; limit 9 trefi
`timescale 1ns/1ps
`include "dsrpd_map.svh"

module dsrpd_lowpower (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 cke,
  input  wire dsrpd_pkg::dsrpd_cmd_t cmd,
  input  wire logic                 banks_open,
  input  wire logic                 ops_busy,
  input  wire logic                 mr0_a12,
  input  wire logic                 mr1_dll_dis,
  output      dsrpd_pkg::dsrpd_stat_t stat,
  output      logic                 pd_overrun
);
  import dsrpd_pkg::*;

  localparam logic [15:0] TCKE   = 16'(`DSRPD_TCKE_CYC);
  localparam logic [15:0] TCKESR = 16'(`DSRPD_TCKESR_CYC);
  localparam logic [15:0] TXS    = 16'(`DSRPD_TXS_CYC);
  localparam logic [15:0] TXP    = 16'(`DSRPD_TXP_CYC);
  localparam logic [15:0] TXPDLL = 16'(`DSRPD_TXPDLL_CYC);
  localparam logic [15:0] TXSDLL = `DSRPD_TXSDLL_CYC;
  localparam logic [15:0] TCPDED = `DSRPD_TCPDED_CYC;
  localparam logic [15:0] REFI   = 16'(`DSRPD_REFI_CYC);
  localparam logic [15:0] PDMAX  = `DSRPD_PD_MAX_REFI;

  // ==========================================================
  // command decode
  logic is_nop;
  logic is_sre;
  assign is_sre = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n && !cke;
  // nop or deselect qualifies power-down edges
  assign is_nop = cmd.cs_n || (cmd.ras_n && cmd.cas_n && cmd.we_n);

  // ==========================================================
  // state and timers
  dsrpd_state_t state, next_state;
  logic [15:0]  res_cnt, next_res_cnt;      // residency / exit delay counter
  logic [15:0]  refi_cnt, next_refi_cnt;    // internal refresh timer
  logic [15:0]  refi_num, next_refi_num;    // trefi periods spent in power-down
  logic [15:0]  dly_cnt, next_dly_cnt;      // txsdll after self-refresh exit
  logic         slow, next_slow;
  logic         dll_on, next_dll_on;
  logic         dll_rst, next_dll_rst;
  logic         ref_req, next_ref_req;
  logic         overrun, next_overrun;

  // next-state logic for all low-power tracking
  always_comb begin
    next_state       = state;
    next_res_cnt     = (res_cnt != 16'h0000) ? res_cnt - 16'h0001 : 16'h0000;
    next_dly_cnt     = (dly_cnt != 16'h0000) ? dly_cnt - 16'h0001 : 16'h0000;
    next_refi_cnt    = refi_cnt;
    next_refi_num    = refi_num;
    next_slow        = slow;
    next_dll_on      = dll_on;
    next_dll_rst     = 1'b0;
    next_ref_req     = 1'b0;
    next_overrun     = overrun;
    unique case (state)
      DSRPD_IDLE: begin
        if (is_sre) begin
          next_state       = DSRPD_SR;
          next_res_cnt     = TCKESR;
          // first internal refresh request comes tcke cycles after entry
          next_refi_cnt    = TCKE - 16'h0001;
          // dll turned off on entry when enabled
          next_dll_on      = 1'b0;
        end else if (!cke && is_nop) begin
          // power-down entry, receivers still live for tcpded
          next_state    = DSRPD_PD_ENT;
          next_res_cnt  = TCPDED;
          next_refi_cnt = REFI - 16'h0001;
          next_refi_num = 16'h0000;
        end
      end
      DSRPD_PD_ENT: begin
        if (res_cnt == 16'h0000) begin
          // settle into precharge or active power-down
          // slow exit only for precharged with a12 low
          next_slow   = !banks_open && !mr0_a12;
          next_state  = banks_open ? DSRPD_APD : DSRPD_PPD;
          next_dll_on = !mr1_dll_dis && (banks_open || mr0_a12);
          next_res_cnt = TCKE;
        end
      end
      DSRPD_PPD, DSRPD_APD: begin
        // power-down duration watch, 9 trefi
        // reload one short so that each period is exactly refi cycles long
        next_refi_cnt = (refi_cnt != 16'h0000) ? refi_cnt - 16'h0001 : REFI - 16'h0001;
        if (refi_cnt == 16'h0000) begin
          next_refi_num = refi_num + 16'h0001;
          if (refi_num + 16'h0001 >= PDMAX)
            next_overrun = 1'b1;
        end
        // exit only after tcke low time, with nop
        if (cke && is_nop && res_cnt == 16'h0000) begin
          next_state   = DSRPD_PD_EXIT;
          next_res_cnt = slow ? TXPDLL : TXP;
          next_dll_on  = !mr1_dll_dis;
          next_dll_rst = slow && !mr1_dll_dis;
        end
      end
      DSRPD_PD_EXIT: begin
        if (res_cnt == 16'h0000)
          next_state = DSRPD_IDLE;
      end
      DSRPD_SR: begin
        // refresh driven by internal timer, no command input
        next_refi_cnt = (refi_cnt != 16'h0000) ? refi_cnt - 16'h0001 : REFI - 16'h0001;
        if (refi_cnt == 16'h0000) begin
          next_ref_req = 1'b1;
        end
        // only cke is looked at while in self-refresh
        if (cke) begin
          // exit on cke high, txs and txsdll start
          next_state   = DSRPD_SR_EXIT;
          next_res_cnt = TXS;
          next_dly_cnt = TXSDLL;
          // dll back on with reset at exit
          next_dll_on  = !mr1_dll_dis;
          next_dll_rst = !mr1_dll_dis;
        end
      end
      DSRPD_SR_EXIT: begin
        if (res_cnt == 16'h0000)
          next_state = DSRPD_IDLE;
      end
      default: next_state = DSRPD_IDLE;
    endcase
    // clear the overrun marker on the next power-down entry from idle
    if (state == DSRPD_IDLE && next_state == DSRPD_PD_ENT)
      next_overrun = 1'b0;
    // dll held off while mr1 disables it, whatever the state asked for
    if (mr1_dll_dis)
      next_dll_on = 1'b0;
  end

  // registers; synchronous reset also breaks out of power-down
  always_ff @(posedge clk) begin
    // reset wins over any power-down state
    if (!reset_n) begin
      state       <= DSRPD_IDLE;
      res_cnt     <= 16'h0000;
      refi_cnt    <= 16'h0000;
      refi_num    <= 16'h0000;
      dly_cnt     <= 16'h0000;
      slow        <= 1'b0;
      dll_on      <= 1'b1;
      dll_rst     <= 1'b0;
      ref_req     <= 1'b0;
      overrun     <= 1'b0;
    end else begin
      state       <= next_state;
      res_cnt     <= next_res_cnt;
      refi_cnt    <= next_refi_cnt;
      refi_num    <= next_refi_num;
      dly_cnt     <= next_dly_cnt;
      slow        <= next_slow;
      dll_on      <= next_dll_on;
      dll_rst     <= next_dll_rst;
      ref_req     <= next_ref_req;
      overrun     <= next_overrun;
    end
  end

  // ==========================================================
  // status outputs
  // state flags decoded from the tracker
  assign stat.in_sr       = (state == DSRPD_SR);
  assign stat.in_ppd      = (state == DSRPD_PPD);
  assign stat.in_apd      = (state == DSRPD_APD);
  assign stat.slow_exit   = slow;
  // buffers off in self-refresh, and in power-down once tcpded has elapsed
  assign stat.buf_off     = (state == DSRPD_PPD) || (state == DSRPD_APD) ||
                            (state == DSRPD_SR);
  assign stat.dll_on      = dll_on;
  assign stat.dll_reset   = dll_rst;
  assign stat.refresh_req = ref_req;
  assign stat.cmd_ok      = (state == DSRPD_IDLE);
  assign stat.dll_cmd_ok  = (state == DSRPD_IDLE) && (dly_cnt == 16'h0000);
  assign pd_overrun       = overrun;

  // ==========================================================
  // checks
  sre_goes_sr_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_IDLE && is_sre) |=> state == DSRPD_SR)
    else $error("self-refresh entry not taken");
  sr_dll_off_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_SR) |-> !dll_on)
    else $error("dll on during self-refresh");
  sr_exit_rst_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_SR && cke && !mr1_dll_dis) |=> dll_rst && state == DSRPD_SR_EXIT)
    else $error("no dll reset at self-refresh exit");
  sr_ignores_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_SR && !cke) |=> state == DSRPD_SR)
    else $error("self-refresh left without cke");
  sr_first_ref_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_IDLE && is_sre) ##1 (!cke)[*2] |=> ref_req)
    else $error("no internal refresh within tcke");
  pd_entry_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_IDLE && !cke && is_nop && !is_sre) |=> state == DSRPD_PD_ENT)
    else $error("power-down entry missed");
  pd_kind_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_PD_ENT && res_cnt == 16'h0000) |=>
      (stat.in_apd == $past(banks_open)) && (stat.in_ppd != $past(banks_open)))
    else $error("wrong power-down kind");
  pd_slow_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_PD_ENT && res_cnt == 16'h0000 && !banks_open && !mr0_a12)
      |=> slow && !dll_on)
    else $error("slow exit mode not set");
  pd_exit_a : assert property (@(posedge clk) disable iff (!reset_n)
    ((state == DSRPD_PPD || state == DSRPD_APD) && cke && is_nop && res_cnt == 16'h0000)
      |=> state == DSRPD_PD_EXIT ##1 !stat.cmd_ok)
    else $error("power-down exit not tracked");
  pd_buf_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_IDLE && !cke && is_nop && !is_sre) |=>
      !stat.buf_off ##1 !stat.buf_off ##1 stat.buf_off)
    else $error("receivers not off right after tcpded");
  rst_exit_a : assert property (@(posedge clk)
    (!reset_n) |=> state == DSRPD_IDLE)
    else $error("reset did not end power-down");
  pd_min_stay_a : assert property (@(posedge clk) disable iff (!reset_n)
    (state == DSRPD_PD_ENT && res_cnt == 16'h0000) |=> (stat.in_ppd || stat.in_apd)[*3])
    else $error("power-down left before tcke");
endmodule

// [hdl/dsrpd_map.svh]
// Purpose: constants for the low-power state logic
// Assumes: 200 MHz device clock, 5 ns period
// Notes:   times kept in ns and the clock period in ps, cycle counts derived from them except txsdll and tcpded
`ifndef DSRPD_MAP_SVH
`define DSRPD_MAP_SVH
`define DSRPD_CLK_PS        16'h1388
`define DSRPD_TCKE_NS       16'h0008
`define DSRPD_TCKESR_NS     16'h000D
`define DSRPD_TXS_NS        16'h00AA
`define DSRPD_TXP_NS        16'h0006
`define DSRPD_TXPDLL_NS     16'h0018
`define DSRPD_TREFI_NS      32'h0000_1E78
`define DSRPD_TCKE_CYC      ((`DSRPD_TCKE_NS * 1000 + `DSRPD_CLK_PS - 1) / `DSRPD_CLK_PS)
`define DSRPD_TCKESR_CYC    ((`DSRPD_TCKESR_NS * 1000 + `DSRPD_CLK_PS - 1) / `DSRPD_CLK_PS)
`define DSRPD_TXS_CYC       ((`DSRPD_TXS_NS * 1000 + `DSRPD_CLK_PS - 1) / `DSRPD_CLK_PS)
`define DSRPD_TXP_CYC       ((`DSRPD_TXP_NS * 1000 + `DSRPD_CLK_PS - 1) / `DSRPD_CLK_PS)
`define DSRPD_TXPDLL_CYC    ((`DSRPD_TXPDLL_NS * 1000 + `DSRPD_CLK_PS - 1) / `DSRPD_CLK_PS)
`define DSRPD_TXSDLL_CYC    16'h0200
`define DSRPD_TCPDED_CYC    16'h0001
`define DSRPD_REFI_CYC      (`DSRPD_TREFI_NS * 1000 / `DSRPD_CLK_PS)
`define DSRPD_PD_MAX_REFI   16'h0009
`endif

// [hdl/dsrpd_pkg.sv]
// Purpose: types for the low-power state logic
// Assumes: nothing beyond the map header
// Notes:   command pins travel as one packed struct
package dsrpd_pkg;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dsrpd_cmd_t;

  // gray only on the idle -> pd entry -> ppd and sr -> sr exit steps
  typedef enum logic [2:0] {
    DSRPD_IDLE    = 3'b000,
    DSRPD_PD_ENT  = 3'b001,
    DSRPD_PPD     = 3'b011,
    DSRPD_APD     = 3'b010,
    DSRPD_SR      = 3'b110,
    DSRPD_SR_EXIT = 3'b111,
    DSRPD_PD_EXIT = 3'b101
  } dsrpd_state_t;

  typedef struct packed {
    logic in_sr;
    logic in_ppd;
    logic in_apd;
    logic slow_exit;
    logic buf_off;
    logic dll_on;
    logic dll_reset;
    logic refresh_req;
    logic cmd_ok;
    logic dll_cmd_ok;
  } dsrpd_stat_t;
endpackage

// [dv/dsrpd_ctrl_model.sv]
// Purpose: controller side of the low-power pins, cke and command
// Assumes: every change after the initial values lands by nonblocking assignment just after a rising clk
// Notes:   bus starts at deselect and rests at nop after an exit; the clock never stops, so it is always stable
`timescale 1ns/1ps

module dsrpd_ctrl_model (
  input  wire logic                  clk,
  output      logic                  cke,
  output      dsrpd_pkg::dsrpd_cmd_t cmd
);
  import dsrpd_pkg::*;

  // deselect with cke high until the first request
  initial begin
    cke = 1'b1;
    cmd = 4'hF;
  end

  // ====================
  // bus drivers
  // one setting per call, held for n sampling edges
  task automatic drive(input logic k, input logic [3:0] c, input int n);
    @(posedge clk);
    cke <= k;
    cmd <= c;
    repeat (n) @(posedge clk);
  endtask

  // called from idle and again while in self-refresh, termination unused
  // cke kept low for n more edges, clock kept running
  task automatic sr_enter(input int n);
    drive(1'b0, 4'h1, 1);
    // a live activate code stays on the pins to show it is ignored
    drive(1'b0, 4'h3, n);
  endtask

  // no write ever follows an exit, so the 512-clock gap holds
  // exit with nop and cke high driven together, held for one edge
  task automatic nop_exit();
    drive(1'b1, 4'h7, 1);
  endtask

  // nop throughout, low for at least tcke
  task automatic pd_enter(input int n);
    drive(1'b0, 4'h7, n);
  endtask
endmodule

// [dv/ddr3_self_refresh_power_down_tb_top.sv]
// Purpose: scenario bench for the self-refresh and power-down state logic
// Assumes: 200 MHz clk, controller model on cke and command pins
// Notes:   exit delays are judged against small windows, not one exact cycle
`timescale 1ns/1ps
`include "dsrpd_map.svh"

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module ddr3_self_refresh_power_down_tb_top;
  import dsrpd_pkg::*;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        banks_open = 1'b0;
  logic        ops_busy = 1'b0;
  logic        mr0_a12 = 1'b0;
  logic        mr1_dll_dis = 1'b0;
  logic        cke;
  dsrpd_cmd_t  cmd;
  dsrpd_stat_t stat;
  logic        pd_overrun;
  int          fail_count = 0;
  int          checks_done = 0;
  int          refs = 0;
  int          dllr = 0;

  dsrpd_ctrl_model ctl (.clk(clk), .cke(cke), .cmd(cmd));

  dsrpd_lowpower uut (.clk(clk), .reset_n(reset_n), .cke(cke), .cmd(cmd),
    .banks_open(banks_open), .ops_busy(ops_busy), .mr0_a12(mr0_a12),
    .mr1_dll_dis(mr1_dll_dis), .stat(stat), .pd_overrun(pd_overrun));

  // 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end

  // one-cycle pulses are counted here so no edge is missed
  always @(posedge clk) begin
    if (stat.refresh_req === 1'b1) refs++;
    if (stat.dll_reset === 1'b1) dllr++;
  end

  // ====================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // bounded wait on cmd_ok or dll_cmd_ok, counted in clocks
  task automatic wait_ok(input bit dll, output int cnt);
    cnt = 0;
    while ((dll ? stat.dll_cmd_ok : stat.cmd_ok) !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (cnt > 600) begin
        fail_count++;
        $display("ERROR wait_ok expected 1 seen timeout");
        tally_and_finish();
      end
    end
  endtask

  // ====================
  // scenarios
  task automatic sc_reset();
    @(negedge clk);
    `CHK("rst in_sr", 1'b0, stat.in_sr)
    `CHK("rst dll_on", 1'b1, stat.dll_on)
    `CHK("rst cmd_ok", 1'b1, stat.cmd_ok)
    `CHK("rst buf_off", 1'b0, stat.buf_off)
  endtask

  task automatic sc_self_refresh();
    int n;
    refs = 0;
    dllr = 0;
    ctl.sr_enter(3);
    @(negedge clk);
    `CHK("sr in_sr", 1'b1, stat.in_sr)
    `CHK("sr dll_on", 1'b0, stat.dll_on)
    `CHK("sr first refresh", 1'b1, refs > 0)
    ctl.sr_enter(20);
    @(negedge clk);
    `CHK("sr ignores cmd", 1'b1, stat.in_sr)
    ctl.nop_exit();
    wait_ok(1'b0, n);
    `CHK("sr txs", 1'b1, n >= `DSRPD_TXS_CYC && n <= `DSRPD_TXS_CYC + 2)
    `CHK("sr exit", 1'b0, stat.in_sr)
    `CHK("sr dll_reset", 1, dllr)
    `CHK("sr dll_cmd_ok", 1'b0, stat.dll_cmd_ok)
    wait_ok(1'b1, n);
    `CHK("sr txsdll", 1'b1, n >= `DSRPD_TXSDLL_CYC - 36 && n <= `DSRPD_TXSDLL_CYC - 32)
  endtask

  // precharge or active power-down, fast or slow exit by a12, dll kept off by dis
  task automatic sc_pd(input logic bo, input logic a12, input logic dis);
    int   n;
    int   lo;
    logic slow;
    slow = !bo && !a12;
    lo = slow ? `DSRPD_TXPDLL_CYC : `DSRPD_TXP_CYC;
    dllr = 0;
    @(posedge clk);
    banks_open <= bo;
    mr0_a12 <= a12;
    mr1_dll_dis <= dis;
    ctl.pd_enter(4);
    @(negedge clk);
    `CHK("pd in_ppd", !bo, stat.in_ppd)
    `CHK("pd in_apd", bo, stat.in_apd)
    `CHK("pd slow_exit", slow, stat.slow_exit)
    `CHK("pd dll_on", !slow && !dis, stat.dll_on)
    `CHK("pd buf_off", 1'b1, stat.buf_off)
    ctl.nop_exit();
    wait_ok(1'b0, n);
    `CHK("pd exit delay", 1'b1, n >= lo && n <= lo + 3)
    `CHK("pd left", 1'b0, stat.in_ppd | stat.in_apd)
    `CHK("pd dll_reset", int'(slow && !dis), dllr)
  endtask

  task automatic sc_reset_in_pd();
    ctl.pd_enter(4);
    @(posedge clk);
    reset_n <= 1'b0;
    // cke stays low, so only the reset can take the device out of power-down
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("rst pd left", 1'b0, stat.in_ppd)
    `CHK("rst pd buf_off", 1'b0, stat.buf_off)
    `CHK("rst pd cmd_ok", 1'b1, stat.cmd_ok)
    ctl.drive(1'b1, 4'hF, 2);
    reset_n <= 1'b1;
  endtask

  task automatic sc_overrun();
    ctl.pd_enter(`DSRPD_REFI_CYC * 9 - 20);
    @(negedge clk);
    `CHK("pd no overrun", 1'b0, pd_overrun)
    ctl.pd_enter(40);
    @(negedge clk);
    `CHK("pd overrun", 1'b1, pd_overrun)
    ctl.nop_exit();
  endtask

  // ====================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    sc_reset();
    sc_self_refresh();
    sc_pd(1'b0, 1'b0, 1'b0);
    sc_pd(1'b1, 1'b0, 1'b0);
    sc_pd(1'b0, 1'b1, 1'b0);
    sc_pd(1'b0, 1'b0, 1'b1);
    sc_reset_in_pd();
    sc_overrun();
    tally_and_finish();
  end
endmodule
